// [ssf_defs.svh]
// Constants for the sensor SPI slave frame handler.
// Assumes inclusion by ssf_pkg and the design modules of this block.
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH
`define SSF_LEN_STD 6'd16
`define SSF_LEN_LONG 6'd17
`define SSF_LEN_CRC 6'd20
`define SSF_LEN_SHARED 6'd21
`define SSF_CRC_PRESET 4'h0
`define SSF_CRC_SEED 4'hF
`define SSF_RW_BIT 14
`define SSF_ADDR_HI 13
`define SSF_ADDR_LO 8
`define SSF_NUM_BYTES 64
`endif

// [ssf_pkg.sv]
// Types for the sensor SPI slave frame handler.
// Assumes the constants header is available on the include path.
`include "ssf_defs.svh"
package ssf_pkg;
  typedef enum logic [1:0] {SSF_IDLE, SSF_FRAME} ssf_phase_t;
  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] csn_sync;
    logic [1:0] mosi_sync;
    logic sclk_d;
    logic csn_d;
    ssf_phase_t phase;
    logic [5:0] bit_cnt;
    logic [20:0] rx_sh;
    logic [19:0] tx_sh;
    logic rd_pend;
    logic [5:0] rd_addr;
    logic miso;
    logic ier;
    logic crc_err;
  } ssf_state_t;
endpackage

// [ssf_regif.sv]
// Interface carrying byte register accesses between frame logic and store.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ns
interface ssf_regif;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic [5:0] rd_addr;
  logic [15:0] rd_data;
  modport master (output wr_en, output wr_addr, output wr_data, output rd_addr,
    input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr,
    output rd_data);
endinterface

// [ssf_regstore.sv]
// Byte-wide register store behind the serial frame handler.
// Assumes writes and reads come from logic on the same clock.
`timescale 1ns/1ns
`include "ssf_defs.svh"
module ssf_regstore
  import ssf_pkg::*;
#(
  parameter int NUM_BYTES = `SSF_NUM_BYTES
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  ssf_regif.store bus // Byte access port.
);
  logic [7:0] mem_r [NUM_BYTES];
  logic [15:0] rd_r;
  logic [5:0] pair_addr;
  assign pair_addr = {bus.rd_addr[5:1], 1'b1};
  assign bus.rd_data = rd_r;
  // Address zero is hardwired to zero and ignores writes.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_BYTES; i++) begin
        mem_r[i] <= 8'h00;
      end
      rd_r <= 16'h0000;
    end else begin
      if (bus.wr_en && bus.wr_addr != 6'd0) begin
        mem_r[bus.wr_addr] <= bus.wr_data;
      end
      if (bus.rd_addr[0]) begin
        rd_r <= {8'h00, mem_r[bus.rd_addr]};
      end else if (bus.rd_addr == 6'd0) begin
        rd_r <= 16'h0000;
      end else begin
        rd_r <= {mem_r[bus.rd_addr], mem_r[pair_addr]};
      end
    end
  end
endmodule

// [ssf_top.sv]
// SPI mode 3 slave frame handler with pipelined reads and 4-bit CRC.
// Assumes SPI pins are asynchronous and sampled on CLK_SYS; SCLK well below CLK_SYS/4.
// Assumes the enables and clears come from logic on CLK_SYS and need no synchroniser.
`timescale 1ns/1ns
`include "ssf_defs.svh"
module ssf_top
  import ssf_pkg::*;
(
  input wire logic CLK_SYS, // System clock, 50 MHz.
  input wire logic RST, // Synchronous reset, active high.
  input wire logic SCLK, // Serial clock from host.
  input wire logic CS_N, // Chip select, active low.
  input wire logic MOSI, // Serial data from host.
  output logic MISO, // Serial data to host.
  output logic MISO_OE, // High during the frame phase, which follows chip select through the synchroniser.
  input wire logic LONG_FRAME_ENABLE, // Allows 17-bit frames.
  input wire logic INBOUND_CRC_CHECK_ENABLE, // Checks host CRC.
  input wire logic IER_CLEAR, // Clears the interface error flag.
  input wire logic CRC_ERR_CLEAR, // Clears the CRC error flag.
  output logic IER_FLAG, // Interface error warning.
  output logic CRC_ERR_FLAG // Inbound CRC error warning.
);
  ssf_state_t s_r, s_nxt;
  ssf_regif rif();
  logic wr_en_nxt;
  logic [5:0] wr_addr_nxt;
  logic [7:0] wr_data_nxt;
  logic wr_en_r;
  logic [5:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic [5:0] fetch_addr_r;

  ////////////////////////////////////////////////////////////////////////////
  // The store registers its read data, so a fetch address needs one cycle.
  // Its address zero always reads as zero and ignores writes.
  ssf_regstore #(.NUM_BYTES(`SSF_NUM_BYTES)) u_store (
    .clk(CLK_SYS),
    .rst(RST),
    .bus(rif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs are taken from registered state.
  // MISO_OE follows the frame phase, not the raw select pin.
  assign rif.wr_en = wr_en_r;
  assign rif.wr_addr = wr_addr_r;
  assign rif.wr_data = wr_data_r;
  assign rif.rd_addr = fetch_addr_r;
  assign MISO = s_r.miso;
  assign MISO_OE = (s_r.phase == SSF_FRAME);
  assign IER_FLAG = s_r.ier;
  assign CRC_ERR_FLAG = s_r.crc_err;

  ////////////////////////////////////////////////////////////////////////////
  // CRC of a 16-bit word, fed MSB first from an all-ones preset.
  function automatic logic [3:0] crc16(input logic [15:0] d);
    logic [3:0] c;
    logic inv;
    c = `SSF_CRC_SEED;
    inv = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      inv = d[i] ^ c[3];
      c = {c[2], c[1], c[0] ^ inv, inv};
    end
    return c;
  endfunction

  // Byte address field of a command word, shared by writes and reads.
  function automatic logic [5:0] cmd_addr(input logic [15:0] w);
    return w[`SSF_ADDR_HI:`SSF_ADDR_LO];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Frame decoding: pin edges, bit shifting and the end-of-frame verdict.
  logic rise, fall, start, stop;
  logic [5:0] n;
  logic [15:0] word;
  logic [15:0] tx_word;
  logic [4:0] tx_idx;
  logic [3:0] rx_crc;
  logic len_ok, too_long, exec, crc_bad;

  always_comb begin
    s_nxt = s_r;
    wr_en_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    word = 16'h0000;
    rx_crc = 4'h0;
    len_ok = 1'b0;
    too_long = 1'b0;
    exec = 1'b0;
    crc_bad = 1'b0;
    n = s_r.bit_cnt;
    // An idle response still carries a correct CRC, of the zero word.
    tx_word = s_r.rd_pend ? rif.rd_data : 16'h0000;
    // Index of the response bit that the next falling edge launches.
    tx_idx = 5'd19 - s_r.bit_cnt[4:0];
    // Pins pass two flops; edges are found between the second flop and its copy.
    s_nxt.sclk_sync = {s_r.sclk_sync[0], SCLK};
    s_nxt.csn_sync = {s_r.csn_sync[0], CS_N};
    s_nxt.mosi_sync = {s_r.mosi_sync[0], MOSI};
    s_nxt.sclk_d = s_r.sclk_sync[1];
    s_nxt.csn_d = s_r.csn_sync[1];
    rise = s_r.sclk_sync[1] && !s_r.sclk_d;
    fall = !s_r.sclk_sync[1] && s_r.sclk_d;
    start = !s_r.csn_sync[1] && s_r.csn_d;
    stop = s_r.csn_sync[1] && !s_r.csn_d;
    // Clears come first so that a flag set in the same cycle wins.
    if (IER_CLEAR) begin
      s_nxt.ier = 1'b0;
    end
    if (CRC_ERR_CLEAR) begin
      s_nxt.crc_err = 1'b0;
    end
    unique case (s_r.phase)
      SSF_IDLE: begin
        if (start) begin
          s_nxt.phase = SSF_FRAME;
          s_nxt.bit_cnt = 6'd0;
          s_nxt.rx_sh = 21'h0;
          // Last read result plus its CRC is loaded; bit 19 drives first.
          s_nxt.tx_sh = {tx_word, crc16(tx_word)};
          s_nxt.miso = s_nxt.tx_sh[19];
        end
      end
      SSF_FRAME: begin
        // The count stops at its top so that a runaway frame still reads as long.
        if (rise && s_r.bit_cnt != 6'h3F) begin
          s_nxt.rx_sh = {s_r.rx_sh[19:0], s_r.mosi_sync[1]};
          s_nxt.bit_cnt = s_r.bit_cnt + 6'd1;
        end
        if (fall && s_r.bit_cnt != 6'd0) begin
          // After 20 shifts the top CRC bit is repeated for a 21st edge.
          if (s_r.bit_cnt == `SSF_LEN_CRC) begin
            s_nxt.miso = s_r.tx_sh[3];
          end else if (s_r.bit_cnt < `SSF_LEN_CRC) begin
            s_nxt.miso = s_r.tx_sh[tx_idx];
          end
        end
        if (stop) begin
          s_nxt.phase = SSF_IDLE;
          s_nxt.miso = 1'b0;
          // Frame length decides the word position and the error outcome.
          unique case (n)
            `SSF_LEN_STD: begin
              word = s_r.rx_sh[15:0];
              len_ok = 1'b1;
            end
            `SSF_LEN_LONG: begin
              word = s_r.rx_sh[16:1];
              len_ok = LONG_FRAME_ENABLE;
              too_long = !LONG_FRAME_ENABLE;
            end
            `SSF_LEN_CRC: begin
              word = s_r.rx_sh[19:4];
              rx_crc = s_r.rx_sh[3:0];
              len_ok = 1'b1;
            end
            `SSF_LEN_SHARED: begin
              // The extra zero trails the CRC, so the content sits one bit higher.
              word = s_r.rx_sh[20:5];
              rx_crc = s_r.rx_sh[4:1];
              len_ok = 1'b1;
            end
            default: begin
              // Short frames are dropped quietly; other long lengths are errors.
              too_long = (n > `SSF_LEN_STD);
            end
          endcase
          if (too_long) begin
            s_nxt.ier = 1'b1;
          end
          exec = len_ok;
          // Only 20 and 21-bit frames carry a CRC from the host.
          crc_bad = (n >= `SSF_LEN_CRC) && (rx_crc != crc16(word));
          if (len_ok && crc_bad && INBOUND_CRC_CHECK_ENABLE) begin
            exec = 1'b0;
            s_nxt.crc_err = 1'b1;
          end
          if (exec) begin
            s_nxt.rd_pend = !word[`SSF_RW_BIT];
            // A write reaches the store through one more register stage.
            if (word[`SSF_RW_BIT]) begin
              wr_en_nxt = 1'b1;
              wr_addr_nxt = cmd_addr(word);
              wr_data_nxt = word[7:0];
            end else begin
              s_nxt.rd_addr = cmd_addr(word);
            end
          end else begin
            // A dropped frame also cancels any read that was pending.
            s_nxt.rd_pend = 1'b0;
          end
        end
      end
      default: begin
        s_nxt.phase = SSF_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // The fetch address follows the next state so read data settle a cycle early.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      // Both pin copies reset to idle high, so no false edge follows reset.
      s_r <= '{sclk_sync: 2'b11, csn_sync: 2'b11, mosi_sync: 2'b00, sclk_d: 1'b1,
               csn_d: 1'b1, phase: SSF_IDLE, bit_cnt: 6'd0, rx_sh: 21'h0,
               tx_sh: 20'h0, rd_pend: 1'b0, rd_addr: 6'd0, miso: 1'b0,
               ier: 1'b0, crc_err: 1'b0};
      wr_en_r <= 1'b0;
      wr_addr_r <= 6'd0;
      wr_data_r <= 8'h00;
      fetch_addr_r <= 6'd0;
    end else begin
      s_r <= s_nxt;
      wr_en_r <= wr_en_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
      fetch_addr_r <= s_nxt.rd_addr;
    end
  end
endmodule

// [ssf_chk.sv]
// Pin-level assertions for ssf_top.
// Assumes a bind to ssf_top from the bench.
`timescale 1ns/1ns
module ssf_chk (
  input wire logic CLK_SYS, // Clock.
  input wire logic RST, // Reset.
  input wire logic SCLK, // Serial clock.
  input wire logic CS_N, // Select.
  input wire logic MISO, // Data out.
  input wire logic MISO_OE, // Enable.
  input wire logic INBOUND_CRC_CHECK_ENABLE, // Check on.
  input wire logic IER_CLEAR, // Clear.
  input wire logic CRC_ERR_CLEAR, // Clear.
  input wire logic IER_FLAG, // Flag.
  input wire logic CRC_ERR_FLAG // Flag.
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  ////////////////////////////////////////
  sequence s_idle;
    CS_N [*8];
  endsequence
  sequence s_bit_held;
    (!CS_N && SCLK) [*8];
  endsequence
  a_idle_quiet: assert property (s_idle |-> !MISO_OE && !MISO)
    else $error("output active outside frame");
  a_oe_active: assert property ((!CS_N) [*6] |-> MISO_OE)
    else $error("output not enabled in frame");
  a_bit_held: assert property (s_bit_held |=> $stable(MISO))
    else $error("data bit changed while clock high");
  a_ier_sticky: assert property (IER_FLAG && !IER_CLEAR |=> IER_FLAG)
    else $error("interface error flag lost");
  a_crc_sticky: assert property (CRC_ERR_FLAG && !CRC_ERR_CLEAR |=> CRC_ERR_FLAG)
    else $error("crc error flag lost");
  a_ier_clears: assert property (s_idle ##0 IER_CLEAR |=> !IER_FLAG)
    else $error("interface error flag not cleared");
  a_ier_at_end: assert property ($rose(IER_FLAG) |-> CS_N)
    else $error("interface error flag set inside frame");
  a_crc_gated: assert property ($rose(CRC_ERR_FLAG) |-> INBOUND_CRC_CHECK_ENABLE)
    else $error("crc error flag set while check off");
endmodule

// [ssf_host.sv]
// Host master model driving mode 3 frames.
// Assumes the bench calls xfer between frames.
`timescale 1ns/1ns
module ssf_host (
  input wire logic clk, // Pacing clock.
  output logic sclk, // Serial clock.
  output logic cs_n, // Select.
  output logic mosi, // Data out.
  input wire logic miso // Data in.
);
  initial begin
    sclk = 1'h1;
    cs_n = 1'h1;
    mosi = 1'h0;
  end
  // Reply bits are taken just before the next fall, as a late-sampling host would.
  task automatic xfer(input int n, input logic [20:0] tx, output logic [20:0] rx);
    rx = '0;
    cs_n <= 1'h0;
    repeat (10) @(negedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      sclk <= 1'h0;
      mosi <= tx[i];
      repeat (4) @(negedge clk);
      sclk <= 1'h1;
      repeat ((i == 0) ? 10 : 4) @(negedge clk);
      rx[i] = miso;
    end
    cs_n <= 1'h1;
    mosi <= !mosi;
    repeat (20) @(negedge clk);
  endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the frame handler.
// Assumes ssf_host drives the serial pins.
`timescale 1ns/1ns
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module tb_top;
  logic clk_sys, rst, sclk, cs_n, mosi, miso, miso_oe;
  logic lfe, icce, ier_clr, crc_clr, ier, crc_err;
  logic [20:0] rx;
  int errors, tests_run;
  ssf_top i_dut (.CLK_SYS(clk_sys), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi),
    .MISO(miso), .MISO_OE(miso_oe), .LONG_FRAME_ENABLE(lfe), .INBOUND_CRC_CHECK_ENABLE(icce),
    .IER_CLEAR(ier_clr), .CRC_ERR_CLEAR(crc_clr), .IER_FLAG(ier), .CRC_ERR_FLAG(crc_err));
  ssf_host i_host (.clk(clk_sys), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////
  function automatic logic [3:0] crc4(input logic [15:0] d);
    logic [3:0] c;
    c = 4'hF;
    for (int i = 15; i >= 0; i--) c = {c[2:1], c[0] ^ d[i] ^ c[3], d[i] ^ c[3]};
    return c;
  endfunction
  task automatic send(input int n, input logic [15:0] c, input logic [3:0] k);
    logic [20:0] tx;
    if (n == 21) tx = {c, k, 1'h0};
    else if (n == 20) tx = {1'h0, c, k};
    else tx = (n >= 16) ? ({5'h00, c} << (n - 16)) : ({5'h00, c} >> (16 - n));
    i_host.xfer(n, tx, rx);
  endtask
  task automatic clr();
    ier_clr = 1'h1;
    crc_clr = 1'h1;
    @(negedge clk_sys);
    ier_clr = 1'h0;
    crc_clr = 1'h0;
  endtask
  task automatic t_rw();
    send(16, 16'h42A5, 4'h0);
    send(16, 16'h433C, 4'h0);
    send(16, 16'h4077, 4'h0);
    send(16, 16'h4188, 4'h0);
    send(16, 16'h0200, 4'h0);
    send(16, 16'h0300, 4'h0);
    `CHK("even read", 16'hA53C, rx[15:0])
    send(16, 16'h0000, 4'h0);
    `CHK("odd read", 16'h003C, rx[15:0])
    send(16, 16'h0000, 4'h0);
    `CHK("zero read", 16'h0000, rx[15:0])
    `CHK("ier clean", 1'h0, ier)
  endtask
  task automatic t_crc();
    logic [3:0] k;
    k = crc4(16'h5500);
    icce = 1'h1;
    send(20, 16'h0200, crc4(16'h0200));
    send(20, 16'h0000, crc4(16'h0000));
    `CHK("data20", 16'hA53C, rx[19:4])
    `CHK("crc20", crc4(16'hA53C), rx[3:0])
    send(20, 16'h45EE, ~crc4(16'h45EE));
    `CHK("crc flag", 1'h1, crc_err)
    clr();
    icce = 1'h0;
    send(20, 16'h4455, ~crc4(16'h4455));
    `CHK("crc ignored", 1'h0, crc_err)
    send(20, 16'h0400, 4'h0);
    icce = 1'h1;
    send(21, 16'h0400, crc4(16'h0400));
    `CHK("data21", 16'h5500, rx[20:5])
    `CHK("crc21", {k, k[3]}, rx[4:0])
    `CHK("ier21", 1'h0, ier)
    `CHK("crc flag 21", 1'h0, crc_err)
    send(16, 16'h0000, 4'h0);
    `CHK("after21", 16'h5500, rx[15:0])
    icce = 1'h0;
  endtask
  task automatic t_len();
    send(17, 16'h4677, 4'h0);
    `CHK("ier 17 off", 1'h1, ier)
    clr();
    lfe = 1'h1;
    send(17, 16'h4711, 4'h0);
    `CHK("ier 17 on", 1'h0, ier)
    send(18, 16'h4677, 4'h0);
    `CHK("ier 18", 1'h1, ier)
    clr();
    send(12, 16'h4677, 4'h0);
    `CHK("ier short", 1'h0, ier)
    send(16, 16'h0600, 4'h0);
    send(16, 16'h0000, 4'h0);
    `CHK("no exec", 16'h0011, rx[15:0])
  endtask
  task automatic report_and_stop();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    rst = 1'h1;
    lfe = 1'h0;
    icce = 1'h0;
    ier_clr = 1'h0;
    crc_clr = 1'h0;
    repeat (20) @(negedge clk_sys);
    rst = 1'h0;
    repeat (5) @(negedge clk_sys);
    t_rw();
    t_crc();
    t_len();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    report_and_stop();
  end
endmodule
bind ssf_top ssf_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .SCLK(SCLK), .CS_N(CS_N),
  .MISO(MISO), .MISO_OE(MISO_OE), .INBOUND_CRC_CHECK_ENABLE(INBOUND_CRC_CHECK_ENABLE),
  .IER_CLEAR(IER_CLEAR), .CRC_ERR_CLEAR(CRC_ERR_CLEAR), .IER_FLAG(IER_FLAG),
  .CRC_ERR_FLAG(CRC_ERR_FLAG));
